// >>> hdl/bcrs_pkg.sv
// constants and rule overview for the bridge clock and reset sequencer
// Overview of operation
// - host logic runs on host clock; PCI feedback is a separate domain
// - PCI clock out is host clock divided by two, phase aligned
// - lock loop aligns the fed-back PCI clock to the internal PCI tree
// - bridge identity latched when power-good rises, then kept
// - identity: grant high, request low gives 01; reverse gives 10
// - internal registers go to defaults while host hard reset is asserted; compat resets them only while it drives hard reset itself
// - PCI bus reset asserted at least one millisecond during reset
// - compat bridge drives configuration values on host data in reset
// - ratio strobe asserts with hard reset, released two clocks later; on aux it is released in the same clock as hard reset
// - all bridges drive reset until identity known; compat holds 1 ms
// - software hard reset request on compat asserts hard reset and resets registers
// - software soft reset on compat pulses warm-start, registers preserved
// - software PCI reset asserts PCI bus reset only, registers preserved
// - self-test on compat: hard reset with warm-start held across reset release
// - host agents sample reset configuration; bridge supplies part of it
package bcrs_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 8000;
    localparam int unsigned RST_MIN_US = 1000;
    localparam int unsigned RST_MIN_CYC =
        (RST_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned RATIO_TAIL_CYC = 2;
    localparam int unsigned INIT_PULSE_CYC = 16;
    localparam int unsigned LOCK_MATCH_CYC = 8;

    // ------------------------------------------------------------------
    // identity encoding and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] IDENT_COMPAT = 2'h1;
    localparam logic [1:0] IDENT_AUX = 2'h2;
    localparam logic [1:0] IDENT_RST = 2'h0;
    localparam int unsigned DEVNUM_W = 5;
    localparam logic [2:0] DEVNUM_BASE_RST = 3'h0;
    localparam int unsigned CFG_W = 16;

    typedef enum logic [2:0] {
        S_WAIT_PG,
        S_HARD,
        S_TAIL,
        S_RUN,
        S_PCI,
        S_INIT,
        S_AUX_HOLD
    } bcrs_state_type;

endpackage

// >>> hdl/bcrs_sequencer.sv
// clock and reset sequencer of the host-to-PCI bridge
`timescale 1ns/1ps
module bcrs_sequencer
    import bcrs_pkg::*;
#(
    parameter int unsigned RST_CYC = RST_MIN_CYC,
    parameter int unsigned INIT_CYC = INIT_PULSE_CYC,
    parameter logic [2:0] DEVNUM_BASE = DEVNUM_BASE_RST
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // power and identity pins
    input wire logic power_good_in_i,
    input wire logic bridge_arb_req_pin_i,
    input wire logic bridge_arb_gnt_pin_i,
    // pci clock
    input wire logic pci_clk_feedback_i,
    output logic pci_clk_o,
    output logic pci_tree_phase_o,
    output logic pll_locked_o,
    // host hard reset, open drain, low active
    input wire logic host_rst_n_i,
    output logic host_rst_n_o,
    output logic host_rst_oe_o,
    // reset outputs
    output logic cpu_ratio_strobe_n_o,
    output logic pci_bus_rst_n_o,
    output logic warm_start_n_o,
    output logic regs_rst_o,
    // configuration values on host data during reset
    input wire logic [bcrs_pkg::CFG_W-1:0] cfg_values_i,
    output logic [bcrs_pkg::CFG_W-1:0] host_data_o,
    output logic host_data_oe_o,
    // software requests, one-cycle pulses
    input wire logic sw_hard_rst_i,
    input wire logic sw_soft_rst_i,
    input wire logic sw_bist_i,
    input wire logic sw_pci_rst_i,
    // status
    output logic [1:0] bridge_ident_o,
    output logic ident_valid_o,
    output logic [bcrs_pkg::DEVNUM_W-1:0] bridge_devnum_o,
    output logic seq_busy_o
);
    import bcrs_pkg::*;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic pg_s;
    logic req_s;
    logic gnt_s;
    logic fb_s;
    logic hrst_n_s;
    logic pg_prev;
    logic pg_rise;

    bcrs_sync #(
        .WIDTH(5)
    ) u_sync (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .d_i({power_good_in_i, bridge_arb_req_pin_i, bridge_arb_gnt_pin_i,
              pci_clk_feedback_i, host_rst_n_i}),
        .q_o({pg_s, req_s, gnt_s, fb_s, hrst_n_s})
    );

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            pg_prev <= 1'b0;
        else
            pg_prev <= pg_s;
    end

    assign pg_rise = pg_s && !pg_prev;

    // pins are active low; a floating or shorted pair decodes as 00
    function automatic logic [1:0] decode_ident(input logic gnt,
                                                input logic req);
        logic [1:0] id;
        id = IDENT_RST;
        if (gnt && !req)
            id = IDENT_COMPAT;
        else if (!gnt && req)
            id = IDENT_AUX;
        return id;
    endfunction

    // ------------------------------------------------------------------
    // identity capture
    // ------------------------------------------------------------------
    logic [1:0] ident;
    logic ident_valid;
    logic compat;

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            ident <= IDENT_RST;
            ident_valid <= 1'b0;
        end
        else if (pg_rise && !ident_valid)
        begin
            ident <= decode_ident(gnt_s, req_s);
            ident_valid <= 1'b1;
        end
        else if (!pg_s)
            ident_valid <= 1'b0;
    end

    assign compat = (ident == IDENT_COMPAT);

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            bridge_devnum_o <= '0;
        else
            bridge_devnum_o <= {DEVNUM_BASE, ident};
    end

    assign bridge_ident_o = ident;
    assign ident_valid_o = ident_valid;

    // ------------------------------------------------------------------
    // pci clock divider and phase lock
    // ------------------------------------------------------------------
    // the feedback is only seen through the synchroniser, so the loop
    // compares it against the divider delayed by the same two stages
    logic [1:0] div_dly;
    logic phase_inv;
    logic [3:0] match_cnt;

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            pci_clk_o <= 1'b0;
        else
            pci_clk_o <= !pci_clk_o;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            div_dly <= 2'h0;
            phase_inv <= 1'b0;
            match_cnt <= 4'h0;
            pll_locked_o <= 1'b0;
            pci_tree_phase_o <= 1'b0;
        end
        else
        begin
            div_dly <= {div_dly[0], pci_clk_o};
            pci_tree_phase_o <= div_dly[1] ^ phase_inv;
            if (fb_s != (div_dly[1] ^ phase_inv))
            begin
                phase_inv <= !phase_inv;
                match_cnt <= 4'h0;
                pll_locked_o <= 1'b0;
            end
            else if (match_cnt != 4'(LOCK_MATCH_CYC))
                match_cnt <= match_cnt + 4'h1;
            else
                pll_locked_o <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // reset sequencing
    // ------------------------------------------------------------------
    bcrs_state_type state;
    bcrs_state_type next_state;
    logic tmr_start;
    logic tmr_done;
    logic [4:0] cyc_cnt;
    logic bist_pend;

    bcrs_timer #(
        .COUNT(RST_CYC)
    ) u_timer (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .start_i(tmr_start),
        .done_o(tmr_done)
    );

    always_comb
    begin
        next_state = state;
        case (state)
            S_WAIT_PG:
                if (pg_rise)
                begin
                    if (decode_ident(gnt_s, req_s) == IDENT_COMPAT)
                        next_state = S_HARD;
                    else
                        next_state = S_AUX_HOLD;
                end
            S_HARD:
                if (tmr_done)
                    next_state = S_TAIL;
            S_TAIL:
                if (cyc_cnt == 5'(RATIO_TAIL_CYC - 1))
                    next_state = S_RUN;
            S_RUN:
                if (compat && (sw_hard_rst_i || sw_bist_i))
                    next_state = S_HARD;
                else if (sw_pci_rst_i)
                    next_state = S_PCI;
                else if (compat && sw_soft_rst_i)
                    next_state = S_INIT;
                else if (!compat && !hrst_n_s)
                    next_state = S_AUX_HOLD;
            S_PCI:
                if (tmr_done)
                    next_state = S_RUN;
            S_INIT:
                if (cyc_cnt == 5'(INIT_CYC - 1))
                    next_state = S_RUN;
            S_AUX_HOLD:
                if (tmr_done && hrst_n_s)
                    next_state = S_RUN;
            default:
                next_state = S_WAIT_PG;
        endcase
        if (!pg_s)
            next_state = S_WAIT_PG;
    end

    assign tmr_start = (next_state != state) &&
                       (next_state == S_HARD || next_state == S_PCI ||
                        next_state == S_AUX_HOLD);

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            state <= S_WAIT_PG;
        else
            state <= next_state;
    end

    // short counts for the ratio tail and the warm-start pulse
    always_ff @(posedge clk_i)
    begin
        if (srst_i || next_state != state)
            cyc_cnt <= 5'h0;
        else if (cyc_cnt != 5'h1f)
            cyc_cnt <= cyc_cnt + 5'h1;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            bist_pend <= 1'b0;
        else if (state == S_RUN && next_state == S_HARD && sw_bist_i)
            bist_pend <= 1'b1;
        else if (next_state != S_HARD && next_state != S_TAIL)
            bist_pend <= 1'b0;
    end

    // ------------------------------------------------------------------
    // registered reset outputs
    // ------------------------------------------------------------------
    logic next_hard;

    assign next_hard = (next_state == S_WAIT_PG) || (next_state == S_HARD);

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            host_rst_oe_o <= 1'b1;
            cpu_ratio_strobe_n_o <= 1'b0;
            pci_bus_rst_n_o <= 1'b0;
            regs_rst_o <= 1'b1;
            warm_start_n_o <= 1'b1;
        end
        else
        begin
            host_rst_oe_o <= next_hard;
            cpu_ratio_strobe_n_o <= !(next_hard ||
                                      next_state == S_TAIL);
            pci_bus_rst_n_o <= !(next_hard || next_state == S_PCI ||
                                 next_state == S_AUX_HOLD);
            regs_rst_o <= next_hard ||
                          next_state == S_AUX_HOLD;
            warm_start_n_o <= !(next_state == S_INIT ||
                                (bist_pend && (next_state == S_HARD ||
                                               next_state == S_TAIL)) ||
                                (state == S_RUN && sw_bist_i &&
                                 next_state == S_HARD));
        end
    end

    // open drain: the pin is only ever pulled low
    assign host_rst_n_o = 1'b0;

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            host_data_o <= '0;
            host_data_oe_o <= 1'b0;
        end
        else
        begin
            host_data_o <= cfg_values_i;
            // only a compatibility bridge reaches the hard state; the
            // captured identity is not yet visible on the capture edge
            host_data_oe_o <= (next_state == S_HARD);
        end
    end

    assign seq_busy_o = (state != S_RUN);

endmodule

// >>> hdl/bcrs_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module bcrs_sync #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // data
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            meta <= '0;
            q_o <= '0;
        end
        else
        begin
            meta <= d_i;
            q_o <= meta;
        end
    end

endmodule

// >>> hdl/bcrs_timer.sv
// down counter for minimum reset durations; done while idle
`timescale 1ns/1ps
module bcrs_timer #(
    parameter int unsigned COUNT = 125000
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // control
    input wire logic start_i,
    output logic done_o
);

    localparam int unsigned CW = $clog2(COUNT + 1);

    logic [CW-1:0] cnt;

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            cnt <= '0;
        else if (start_i)
            cnt <= CW'(COUNT);
        else if (cnt != '0)
            cnt <= cnt - CW'(1);
    end

    assign done_o = (cnt == '0) && !start_i;

endmodule

// >>> verification/bcrs_checker.sv
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
module bcrs_checker
    import bcrs_pkg::*;
#(
    parameter int unsigned RST_CYC = RST_MIN_CYC,
    parameter logic [2:0] DEVNUM_BASE = DEVNUM_BASE_RST
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // software requests
    input wire logic sw_hard_rst_i,
    input wire logic sw_soft_rst_i,
    input wire logic sw_bist_i,
    input wire logic sw_pci_rst_i,
    // watched outputs
    input wire logic host_rst_oe_o,
    input wire logic cpu_ratio_strobe_n_o,
    input wire logic pci_bus_rst_n_o,
    input wire logic warm_start_n_o,
    input wire logic regs_rst_o,
    input wire logic host_data_oe_o,
    input wire logic [1:0] bridge_ident_o,
    input wire logic ident_valid_o,
    input wire logic [bcrs_pkg::DEVNUM_W-1:0] bridge_devnum_o,
    input wire logic seq_busy_o
);
    logic [31:0] low_cnt;
    logic compat;
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    assign compat = (bridge_ident_o == IDENT_COMPAT);
    // counts low cycles so the minimum length is checked, not a shape
    always_ff @(posedge clk_i)
    begin
        if (srst_i || pci_bus_rst_n_o)
            low_cnt <= 32'h0;
        else
            low_cnt <= low_cnt + 32'h1;
    end
    strobe_with_rst_a: assert property (
        host_rst_oe_o && compat |-> !cpu_ratio_strobe_n_o)
        else $error("ratio strobe idle while hard reset driven");
    strobe_tail_a: assert property (
        $fell(host_rst_oe_o) && compat |-> !cpu_ratio_strobe_n_o
        ##1 !cpu_ratio_strobe_n_o ##1 cpu_ratio_strobe_n_o)
        else $error("ratio strobe tail not two clocks");
    pci_rst_min_a: assert property (
        $rose(pci_bus_rst_n_o) |-> low_cnt >= RST_CYC)
        else $error("pci reset released too early");
    regs_in_hard_a: assert property (
        host_rst_oe_o |-> regs_rst_o)
        else $error("registers not reset during hard reset");
    cfg_drive_a: assert property (
        host_data_oe_o |-> host_rst_oe_o)
        else $error("host data driven outside hard reset");
    ident_hold_a: assert property (
        ident_valid_o && $past(ident_valid_o) |-> $stable(bridge_ident_o))
        else $error("captured identity changed");
    devnum_map_a: assert property (
        ident_valid_o |=>
        bridge_devnum_o == {DEVNUM_BASE, $past(bridge_ident_o)})
        else $error("device number does not follow identity");
    bist_warm_a: assert property (
        $fell(host_rst_oe_o) && !warm_start_n_o |->
        !$past(warm_start_n_o) ##1 !warm_start_n_o ##1 warm_start_n_o)
        else $error("warm start not held over reset release");
    hard_req_a: assert property (
        sw_hard_rst_i && !seq_busy_o && compat |=>
        host_rst_oe_o && regs_rst_o && !pci_bus_rst_n_o)
        else $error("hard reset request not obeyed");
    pci_only_a: assert property (
        sw_pci_rst_i && !sw_hard_rst_i && !sw_bist_i && !seq_busy_o
        |=> !pci_bus_rst_n_o && !host_rst_oe_o && !regs_rst_o)
        else $error("pci reset request disturbed host side");
    soft_keep_a: assert property (
        sw_soft_rst_i && !sw_hard_rst_i && !sw_bist_i && !sw_pci_rst_i
        && !seq_busy_o && compat |=> !warm_start_n_o && !regs_rst_o)
        else $error("soft reset lost registers or no warm start");
endmodule

bind bcrs_sequencer bcrs_checker #(
    .RST_CYC(RST_CYC),
    .DEVNUM_BASE(DEVNUM_BASE)
) u_chk (
    .clk_i, .srst_i, .sw_hard_rst_i, .sw_soft_rst_i, .sw_bist_i,
    .sw_pci_rst_i, .host_rst_oe_o, .cpu_ratio_strobe_n_o,
    .pci_bus_rst_n_o, .warm_start_n_o, .regs_rst_o, .host_data_oe_o,
    .bridge_ident_o, .ident_valid_o, .bridge_devnum_o, .seq_busy_o
);

// >>> verification/bcrs_partner.sv
// far side: supply, strap resistors, reset wire, pci clock buffer
`timescale 1ns/1ps
module bcrs_partner (
    // bench controls
    input wire logic clk_i,
    input wire logic pg_req_i,
    input wire logic aux_i,
    input wire logic ext_rst_i,
    // from the bridge
    input wire logic host_rst_oe_i,
    input wire logic pci_clk_i,
    input wire logic ratio_strobe_n_i,
    // to the bridge
    output logic power_good_o,
    output logic req_pin_o,
    output logic gnt_pin_o,
    output logic pci_fb_o,
    output logic host_rst_n_o,
    // to the processors
    output logic [1:0] core_ratio_o,
    output logic [1:0] arb_id_o
);
    // arbitrary bus-to-core ratio presented by the board mux
    localparam logic [1:0] CORE_RATIO = 2'h2;
    logic [3:0] run_cnt = 4'h0;
    always @(posedge clk_i)
        if (run_cnt != 4'ha)
            run_cnt <= run_cnt + 4'h1;
    assign power_good_o = pg_req_i && (run_cnt == 4'ha);
    // strap resistors: one pin pulled up, the other down
    assign gnt_pin_o = !aux_i;
    assign req_pin_o = aux_i;
    // pulled-up wire: any agent may hold it low
    assign host_rst_n_o = !(host_rst_oe_i || ext_rst_i);
    // buffered copy returns with board skew
    assign #2 pci_fb_o = pci_clk_i;
    // ratio mux only steers the processor pins while the strobe is low
    assign core_ratio_o = ratio_strobe_n_i ? 2'h0 : CORE_RATIO;
    // agent id comes from the memory controller model, never the bridge
    assign arb_id_o = 2'h3;
endmodule

// >>> verification/testbench.sv
// self-checking bench for the clock and reset sequencer
`timescale 1ns/1ps
module testbench;
    import bcrs_pkg::*;
    localparam int RC = 20;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic pg_req = 1'b0;
    logic aux = 1'b1;
    logic ext_rst = 1'b1;
    logic sw_hard_rst_i = 1'b0;
    logic sw_soft_rst_i = 1'b0;
    logic sw_bist_i = 1'b0;
    logic sw_pci_rst_i = 1'b0;
    logic [CFG_W-1:0] cfg_values_i = 16'h5a3c;
    logic pg, req, gnt, fb, hrst_n, pclk, locked, oe, strobe_n, pci_n;
    logic warm_n, regs_rst, hd_oe, valid, busy, x, tree, hrst_o;
    logic [CFG_W-1:0] hdata;
    logic [1:0] ident, ratio, arb;
    logic [DEVNUM_W-1:0] devnum;
    int miscompares = 0;
    int checked = 0;
    int cyc = 0;
    int a, b, c, d;
    wire [3:0] lows = {~oe, strobe_n, pci_n, warm_n};
    always #4 clk_i = ~clk_i;
    bcrs_partner u_far (.clk_i(clk_i), .pg_req_i(pg_req), .aux_i(aux),
        .ext_rst_i(ext_rst), .host_rst_oe_i(oe), .pci_clk_i(pclk),
        .ratio_strobe_n_i(strobe_n), .power_good_o(pg), .req_pin_o(req),
        .gnt_pin_o(gnt), .pci_fb_o(fb), .host_rst_n_o(hrst_n),
        .core_ratio_o(ratio), .arb_id_o(arb));
    bcrs_sequencer #(.RST_CYC(RC)) u_dut (.clk_i(clk_i), .srst_i(srst_i),
        .power_good_in_i(pg), .bridge_arb_req_pin_i(req),
        .bridge_arb_gnt_pin_i(gnt), .pci_clk_feedback_i(fb),
        .pci_clk_o(pclk), .pci_tree_phase_o(tree), .pll_locked_o(locked),
        .host_rst_n_i(hrst_n), .host_rst_n_o(hrst_o), .host_rst_oe_o(oe),
        .cpu_ratio_strobe_n_o(strobe_n), .pci_bus_rst_n_o(pci_n),
        .warm_start_n_o(warm_n), .regs_rst_o(regs_rst),
        .cfg_values_i(cfg_values_i), .host_data_o(hdata),
        .host_data_oe_o(hd_oe), .sw_hard_rst_i(sw_hard_rst_i),
        .sw_soft_rst_i(sw_soft_rst_i), .sw_bist_i(sw_bist_i),
        .sw_pci_rst_i(sw_pci_rst_i), .bridge_ident_o(ident),
        .ident_valid_o(valid), .bridge_devnum_o(devnum),
        .seq_busy_o(busy));
    task automatic conclude();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask
    // length of the current low phase, from this cycle on
    task automatic span(input int k, output int n);
        n = 0;
        while (lows[k] === 1'b0 && n < 500)
        begin
            tick();
            n++;
        end
    endtask
    task automatic spans();
        fork
            span(3, a);
            span(1, b);
            span(2, c);
            span(0, d);
        join
    endtask
    task automatic idle();
        repeat (200)
            if (busy !== 1'b0)
                tick();
    endtask
    // 0 hard, 1 soft, 2 self-test, 3 pci; returns in the answer cycle
    task automatic pulse(input int k);
        @(posedge clk_i);
        {sw_hard_rst_i, sw_soft_rst_i, sw_bist_i, sw_pci_rst_i} <= 4'h8 >> k;
        @(posedge clk_i);
        {sw_hard_rst_i, sw_soft_rst_i, sw_bist_i, sw_pci_rst_i} <= 4'h0;
        #1;
    endtask
    task automatic power_up(input logic x_aux);
        @(posedge clk_i);
        srst_i <= 1'b1;
        pg_req <= 1'b0;
        aux <= x_aux;
        repeat (6) @(posedge clk_i);
        srst_i <= 1'b0;
        tick();
        check(oe, 1);
        check({strobe_n, pci_n, regs_rst}, 3'h1);
        check(ident, IDENT_RST);
        @(posedge clk_i);
        pg_req <= 1'b1;
        repeat (20)
            if (valid !== 1'b1)
                tick();
    endtask
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            miscompares++;
            conclude();
        end
    end
    initial
    begin
        power_up(1'b1);
        check(ident, IDENT_AUX);
        check(oe, 0);
        repeat (RC + 5) tick();
        check({pci_n, regs_rst}, 2'h1);
        @(posedge clk_i);
        ext_rst <= 1'b0;
        idle();
        check({pci_n, ident}, {1'b1, IDENT_AUX});
        pulse(0);
        check({oe, busy}, 2'h0);
        pulse(3);
        check({pci_n, regs_rst}, 2'h0);
        spans();
        check(b, RC + 1);
        $display("test aux bridge done");
        power_up(1'b0);
        check(ident, IDENT_COMPAT);
        check({hd_oe, regs_rst}, 2'h3);
        check(hdata, cfg_values_i);
        check(ratio, 2'h2);
        check(arb, 2'h3);
        check(hrst_o, 1'b0);
        spans();
        check(c - a, 2);
        check(ratio, 2'h0);
        check(b >= RC, 1);
        check(devnum, {DEVNUM_BASE_RST, IDENT_COMPAT});
        $display("test power up done");
        idle();
        pulse(0);
        check({regs_rst, hd_oe}, 2'h3);
        spans();
        check(a, RC + 1);
        check(c, RC + 3);
        check(b, RC + 1);
        $display("test hard reset done");
        idle();
        pulse(2);
        spans();
        check(d, RC + 3);
        check(a, RC + 1);
        $display("test self-test done");
        idle();
        pulse(1);
        check({oe, regs_rst}, 2'h0);
        spans();
        check(d, INIT_PULSE_CYC);
        check(locked, 1);
        check(tree, !pclk);
        x = pclk;
        tick();
        check(pclk, !x);
        $display("test soft reset and clocks done");
        conclude();
    end
endmodule
